// ---- inc/mpd_pkg.sv ----
// package for the motor parameter code decoder
package mpd_pkg;
  localparam int CODE_W = 7;
  localparam int EXP_W = 3;
  localparam int MANT_W = 4;
  localparam int LIN_W = 11;
  localparam logic [LIN_W-1:0] LIN_MAX = 11'h780;
  localparam logic [MANT_W-1:0] MANT_TAB_MIN = 4'h8;
  // wishbone map, byte addresses
  localparam logic [3:0] ADR_RES_CODE = 4'h0;
  localparam logic [3:0] ADR_BEMF_CODE = 4'h4;
  localparam logic [3:0] ADR_RES_LIN = 4'h8;
  localparam logic [3:0] ADR_BEMF_LIN = 4'hc;
  localparam logic [CODE_W-1:0] CODE_RST = 7'h00;

  typedef struct packed {
    logic [EXP_W-1:0] exponent;
    logic [MANT_W-1:0] mantissa;
  } mpd_code_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } mpd_wb_req_t;

  typedef struct packed {
    logic [1:0] rst_sync;
    mpd_code_t res_code;
    mpd_code_t bemf_code;
    logic [LIN_W-1:0] res_lin;
    logic [LIN_W-1:0] bemf_lin;
    logic ack;
    logic err;
    logic [31:0] rdat;
  } mpd_state_t;
endpackage

// ---- rtl/mpd_expand.sv ----
// shift-and-mantissa expander for one 7-bit code
`timescale 1ns/1ps
`default_nettype none
module mpd_expand (
  input wire mpd_pkg::mpd_code_t code_i,
  output logic [mpd_pkg::LIN_W-1:0] lin_o
);
  import mpd_pkg::*;
  // same formula for every code, no error flag
  assign lin_o = LIN_W'({7'h00, code_i.mantissa} << code_i.exponent);
endmodule
`default_nettype wire

// ---- rtl/mpd_top.sv ----
// motor parameter code decoder with wishbone registers
//
// The Wishbone slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - back-emf code is exponent and mantissa; value is mantissa shifted by exponent.
// - back-emf code 0x7f decodes to 1920.
// - back-emf code 0x01 decodes to one.
// - resistance code zero gives zero, all-ones gives the largest value.
// - resistance code expands as mantissa shifted by exponent.
module mpd_top (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  output logic [mpd_pkg::LIN_W-1:0] res_lin_o,
  output logic [mpd_pkg::LIN_W-1:0] bemf_lin_o
);
  import mpd_pkg::*;

  mpd_state_t st_reg;
  mpd_state_t st_next;
  mpd_wb_req_t req;
  logic [LIN_W-1:0] res_exp;
  logic [LIN_W-1:0] bemf_exp;
  logic rst_n;

  assign rst_n = st_reg.rst_sync[1];
  assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, adr: wb_adr_i,
                 sel: wb_sel_i, dat: wb_dat_i};

  // ************************************
  // expanders
  // ************************************
  mpd_code_t code_vec [2];
  logic [LIN_W-1:0] lin_vec [2];
  assign code_vec[0] = st_reg.res_code;
  assign code_vec[1] = st_reg.bemf_code;
  // one expander per code, both share the same formula
  for (genvar g = 0; g < 2; g++) begin : g_expand
    mpd_expand i_mpd_expand (
      .code_i(code_vec[g]),
      .lin_o(lin_vec[g])
    );
  end
  assign res_exp = lin_vec[0];
  assign bemf_exp = lin_vec[1];

  function automatic logic adr_known(input logic [3:0] a);
    adr_known = (a == ADR_RES_CODE) || (a == ADR_BEMF_CODE) ||
                (a == ADR_RES_LIN) || (a == ADR_BEMF_LIN);
  endfunction

  // ************************************
  // next state
  // ************************************
  always_comb begin
    st_next = st_reg;
    st_next.rst_sync = {st_reg.rst_sync[0], 1'b1};
    // outputs registered so downstream sees a stable value
    st_next.res_lin = res_exp;
    st_next.bemf_lin = bemf_exp;
    st_next.ack = 1'b0;
    st_next.err = 1'b0;
    if (req.cyc && req.stb && !st_reg.ack && !st_reg.err) begin
      if (!adr_known(req.adr)) begin
        st_next.err = 1'b1;
      end else begin
        st_next.ack = 1'b1;
        case (req.adr)
          ADR_RES_CODE: st_next.rdat = {25'h0, st_reg.res_code};
          ADR_BEMF_CODE: st_next.rdat = {25'h0, st_reg.bemf_code};
          ADR_RES_LIN: st_next.rdat = {21'h0, st_reg.res_lin};
          ADR_BEMF_LIN: st_next.rdat = {21'h0, st_reg.bemf_lin};
          default: st_next.rdat = 32'h0;
        endcase
      end
    end
    // the write lands on the edge at which the master samples ack, so a
    // request dropped before its answer leaves the codes alone;
    // code bytes live in lane 0 and the linear words are read-only
    if (req.cyc && req.stb && req.we && req.sel[0] && st_reg.ack) begin
      if (req.adr == ADR_RES_CODE) begin
        st_next.res_code = req.dat[CODE_W-1:0];
      end
      if (req.adr == ADR_BEMF_CODE) begin
        st_next.bemf_code = req.dat[CODE_W-1:0];
      end
    end
  end

  // sync releases on first edges regardless of enable
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_reg <= '0;
    end else if (!rst_n) begin
      st_reg <= '0;
      st_reg.rst_sync <= st_next.rst_sync;
    end else if (clk_en_i) begin
      st_reg <= st_next;
    end
  end

  assign wb_ack_o = st_reg.ack;
  assign wb_err_o = st_reg.err;
  assign wb_dat_o = st_reg.rdat;
  assign res_lin_o = st_reg.res_lin;
  assign bemf_lin_o = st_reg.bemf_lin;

  // ************************************
  // checks
  // ************************************
  chk_bemf_max_value: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    (clk_en_i && st_reg.bemf_code == 7'h7f) |=> (bemf_lin_o == LIN_MAX))
    else $error("bemf max code not 1920");
  chk_bemf_min_value: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    (clk_en_i && st_reg.bemf_code == 7'h01) |=> (bemf_lin_o == 11'h001))
    else $error("bemf min code not one");
  chk_res_zero_code: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    (clk_en_i && st_reg.res_code == 7'h00) |=> (res_lin_o == 11'h000))
    else $error("res zero code not zero");
  chk_res_max_code: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    (clk_en_i && st_reg.res_code == 7'h7f) |=> (res_lin_o == LIN_MAX))
    else $error("res max code not largest");
  chk_bemf_shift_formula: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    clk_en_i |=> (bemf_lin_o == ({7'h0, $past(st_reg.bemf_code.mantissa)}
                  << $past(st_reg.bemf_code.exponent))))
    else $error("bemf decode mismatch");
  chk_res_shift_formula: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    clk_en_i |=> (res_lin_o == ({7'h0, $past(st_reg.res_code.mantissa)}
                 << $past(st_reg.res_code.exponent))))
    else $error("res decode mismatch");
  chk_untab_no_error: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    (clk_en_i && st_reg.res_code.exponent != 3'h0 && st_reg.res_code.mantissa < MANT_TAB_MIN)
    |=> (res_lin_o != 11'h000 || $past(st_reg.res_code.mantissa) == 4'h0))
    else $error("untabulated code lost");
  chk_wb_ack_pulse: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    wb_ack_o && clk_en_i |=> !wb_ack_o)
    else $error("ack held two cycles");

  // ************************************
  // bus checks
  // ************************************
  // answers come one edge after the taking edge, never both at once
  chk_ack_err_apart: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    !(wb_ack_o && wb_err_o))
    else $error("ack and err together");
  chk_wb_err_pulse: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    wb_err_o && clk_en_i |=> !wb_err_o)
    else $error("err held two cycles");
  chk_ack_on_known: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    (clk_en_i && wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o && adr_known(wb_adr_i))
    |=> (wb_ack_o && !wb_err_o))
    else $error("mapped request not acked");
  chk_err_on_unknown: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    (clk_en_i && wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o && !adr_known(wb_adr_i))
    |=> (wb_err_o && !wb_ack_o))
    else $error("unmapped request not refused");
  chk_idle_no_answer: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    (clk_en_i && !(wb_cyc_i && wb_stb_i)) |=> (!wb_ack_o && !wb_err_o))
    else $error("answer without request");
  // read words carry the value seen on the taking edge, upper bits zero
  chk_rdat_res_lin: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    (clk_en_i && wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o && wb_adr_i == ADR_RES_LIN)
    |=> (wb_dat_o[LIN_W-1:0] == $past(res_lin_o) && wb_dat_o[31:LIN_W] == '0))
    else $error("res linear read wrong");
  chk_rdat_bemf_lin: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    (clk_en_i && wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o && wb_adr_i == ADR_BEMF_LIN)
    |=> (wb_dat_o[LIN_W-1:0] == $past(bemf_lin_o) && wb_dat_o[31:LIN_W] == '0))
    else $error("bemf linear read wrong");
  chk_rdat_res_code: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    (clk_en_i && wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o && wb_adr_i == ADR_RES_CODE)
    |=> (wb_dat_o[CODE_W-1:0] == $past(st_reg.res_code) && wb_dat_o[31:CODE_W] == '0))
    else $error("res code read wrong");
  // codes move only on the acked edge of a lane 0 write
  chk_write_bemf_code: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    (clk_en_i && wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] &&
     wb_adr_i == ADR_BEMF_CODE) |=> (st_reg.bemf_code == $past(wb_dat_i[CODE_W-1:0])))
    else $error("back-emf code write lost");
  chk_write_res_code: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    (clk_en_i && wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] &&
     wb_adr_i == ADR_RES_CODE) |=> (st_reg.res_code == $past(wb_dat_i[CODE_W-1:0])))
    else $error("resistance code write lost");
  chk_write_on_ack: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    (clk_en_i && !wb_ack_o) |=> ($stable(st_reg.res_code) && $stable(st_reg.bemf_code)))
    else $error("code moved without ack");
  chk_lane_masked: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    (wb_ack_o && !wb_sel_i[0]) |=> ($stable(st_reg.res_code) && $stable(st_reg.bemf_code)))
    else $error("masked write changed a code");
  chk_lin_read_only: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    (wb_ack_o && (wb_adr_i == ADR_RES_LIN || wb_adr_i == ADR_BEMF_LIN))
    |=> ($stable(st_reg.res_code) && $stable(st_reg.bemf_code)))
    else $error("linear word write changed a code");

  // ************************************
  // decode and enable checks
  // ************************************
  // enable low holds everything, the released sync included
  chk_freeze_state: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    !clk_en_i |=> $stable(st_reg))
    else $error("state moved with enable low");
  // no code, tabulated or not, can reach past the top value
  chk_lin_upper_bound: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    res_lin_o <= LIN_MAX && bemf_lin_o <= LIN_MAX)
    else $error("linear value above 1920");
  chk_zero_mantissa: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    (clk_en_i && st_reg.bemf_code.mantissa == 4'h0) |=> (bemf_lin_o == 11'h000))
    else $error("zero mantissa not zero");
  // outputs stay quiet until the sync copy of reset lets go
  chk_reset_quiet: assert property (@(posedge core_clk_i)
    !rst_n |-> (!wb_ack_o && !wb_err_o && res_lin_o == '0 && bemf_lin_o == '0))
    else $error("outputs live during reset");
endmodule
`default_nettype wire

// ---- bench/mpd_top_tb.sv ----
// self-checking bench for the motor parameter code decoder
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin samples_checked++; if ((e) !== (s)) begin mismatches++; \
  $display("ERROR %s expected %0h seen %0h", n, e, s); end end
module mpd_top_tb;
  import mpd_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cen = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [3:0] sel = 4'hf;
  logic [31:0] dat = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic wb_err_o;
  logic [LIN_W-1:0] res_lin_o;
  logic [LIN_W-1:0] bemf_lin_o;
  logic [15:0] lfsr = 16'h0041;
  logic [31:0] q;
  logic e;
  int mismatches = 0;
  int samples_checked = 0;
  int rv;
  mpd_top i_mpd_top (.core_clk_i(clk), .reset_n_i(rst_n), .clk_en_i(cen), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .res_lin_o(res_lin_o),
    .bemf_lin_o(bemf_lin_o));
  // ****************
  // clock, helpers
  // ****************
  initial begin
    forever #20 clk = ~clk;
  end
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // reference decode: mantissa shifted by exponent, no special cases
  function automatic int model(input int c);
    return (c & 15) << (c >> 4);
  endfunction
  // software side: smallest exponent whose rounded mantissa fits four bits
  function automatic int encode(input int lin);
    int s;
    int m;
    s = 0;
    m = lin;
    while (m > 15 && s < 7) begin
      s++;
      m = (lin + (1 << (s - 1))) >> s;
    end
    return (s << 4) | m;
  endfunction
  // entered just after a rising edge; answer taken at the edge that samples it
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                    output logic [31:0] rd, output logic er);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk);
    end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
    rd = wb_dat_o;
    er = wb_err_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic test_done();
    if (mismatches == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ****************
  // scenarios
  // ****************
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK("res_lin_reset", 11'h000, res_lin_o)
    // every back-emf code, random resistance codes alongside
    for (int i = 0; i < 128; i++) begin
      rv = int'(lfsr[6:0]);
      lfsr = lfsr_next(lfsr);
      wb(1'b1, ADR_BEMF_CODE, {lfsr, 9'h000, 7'(i)}, q, e);
      wb(1'b1, ADR_RES_CODE, {lfsr, 9'h000, 7'(rv)}, q, e);
      wb(1'b0, ADR_BEMF_LIN, 32'h0, q, e);
      `CHK("bemf_lin", 11'(model(i)), bemf_lin_o)
      `CHK("res_lin", 11'(model(rv)), res_lin_o)
      `CHK("bemf_lin_word", 32'(model(i)), q)
    end
    wb(1'b1, ADR_RES_CODE, 32'h0000007f, q, e);
    wb(1'b0, ADR_RES_CODE, 32'h0, q, e);
    `CHK("res_lin_max", 11'h780, res_lin_o)
    `CHK("res_code_word", 32'h0000007f, q)
    wb(1'b0, 4'h2, 32'h0, q, e);
    `CHK("unmapped_err", 1'b1, e)
    // weighted, scaled and rounded by software before encoding
    wb(1'b1, ADR_BEMF_CODE, 32'(encode((1090 * 1760) / 1000)), q, e);
    wb(1'b1, ADR_RES_CODE, 32'(encode((18500000 + 4835) / 9670)), q, e);
    wb(1'b0, ADR_BEMF_LIN, 32'h0, q, e);
    `CHK("bemf_lin_top", 11'h780, bemf_lin_o)
    `CHK("res_lin_top", 11'h780, res_lin_o)
    wb(1'b1, ADR_BEMF_CODE, 32'(encode((1090 * 92 + 50000) / 100000)), q, e);
    wb(1'b1, ADR_RES_CODE, 32'(encode((29000 + 4835) / 9670)), q, e);
    wb(1'b0, ADR_BEMF_LIN, 32'h0, q, e);
    `CHK("bemf_lin_bottom", 11'h001, bemf_lin_o)
    `CHK("res_lin_bottom", 11'h003, res_lin_o)
    // lane 0 off and read-only words leave the code alone
    sel <= 4'he;
    wb(1'b1, ADR_RES_CODE, 32'h00000011, q, e);
    sel <= 4'hf;
    wb(1'b1, ADR_RES_LIN, 32'h00000011, q, e);
    wb(1'b0, ADR_RES_CODE, 32'h0, q, e);
    `CHK("res_code_kept", 32'h00000003, q)
    // enable low keeps the request untaken until it rises
    cen <= 1'b0;
    fork
      wb(1'b0, ADR_RES_LIN, 32'h0, q, e);
      begin
        repeat (5) @(posedge clk);
        `CHK("ack_frozen", 1'b0, wb_ack_o)
        cen <= 1'b1;
      end
    join
    `CHK("res_lin_frozen_read", 32'h00000003, q)
    test_done();
  end
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    test_done();
  end
endmodule
`default_nettype wire
